/* src/shift_clock_divider.sv */
// Baud tick generator: one tick every divisor+1 clocks, each tick a half period.
// Assumes the divisor is static while the generator runs.
`default_nettype none

module shift_clock_divider (
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic       hold_in,
  input  wire logic [7:0] divisor_in,
  output logic            tick_out
);

  logic [7:0] count_r;

  // Counter restarts from zero whenever held, so the first half period is full.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_r <= 8'h00;
    end else if (hold_in || tick_out) begin
      count_r <= 8'h00;
    end else begin
      count_r <= count_r + 8'h01;
    end
  end

  // Tick is suppressed while held.
  assign tick_out = !hold_in && (count_r == divisor_in);

endmodule : shift_clock_divider

`default_nettype wire

/* src/sync_master_serial_receiver.sv */
// Synchronous master receive path with AHB-Lite register slave and two-deep FIFO.
// Assumes a single AHB master, word transfers only, and synchronous pin inputs.
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`default_nettype none

module sync_master_serial_receiver
  import sync_rx_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // AHB-Lite slave.
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Receive interrupt request.
  output logic             rx_irq_out,
  // Shift clock pin.
  output logic             serial_clock_out,
  output logic             serial_clock_oe_out,
  // Data pin and the transmitter's bit that it carries when not receiving.
  input  wire logic        serial_data_pin_in,
  output logic             serial_data_pin_out,
  output logic             serial_data_pin_oe_out,
  input  wire logic        tx_serial_bit_in
);

  ctrl_t      ctrl_r;
  logic       receive_interrupt_enable_r;
  logic [7:0] baud_divisor_r;
  logic       overrun_error_bit_r;
  rx_state_t  state_r;
  logic [3:0] bit_count_r;
  logic [8:0] receive_shift_register_r;
  rx_entry_t  fifo_r [2];
  logic       rd_ptr_r;
  logic [1:0] count_r;
  logic       clock_level_r;
  logic       data_pin_r;
  logic       rd_wait_r;
  logic [7:0] rd_idx_r;
  logic       wr_pend_r;
  logic [7:0] wr_idx_r;
  logic [31:0] rd_mux;
  logic       tick;
  logic       rx_active;
  logic       brg_hold;
  logic       last_sample;
  logic       pop;
  logic       push;
  logic       has_space;
  logic       wr_status;
  logic       receive_complete_flag;
  rx_entry_t  head;
  logic [3:0] last_bit;

  // Master mode needs port, sync and clock source; either enable arms reception.
  assign rx_active = ctrl_r.serial_port_enable && ctrl_r.sync_mode &&
                     ctrl_r.clock_source_master &&
                     (ctrl_r.single_receive_enable ||
                      ctrl_r.continuous_receive_enable);
  assign brg_hold  = !(ctrl_r.transmit_enable || ctrl_r.single_receive_enable ||
                       ctrl_r.continuous_receive_enable);
  assign last_bit  = ctrl_r.nine_bit_receive_enable ? LAST_BIT_NINE
                                                    : LAST_BIT_EIGHT;
  assign last_sample = (state_r == ST_HIGH) && tick && (bit_count_r == last_bit);

  shift_clock_divider u_div (
    .clk_in     (clk_in),
    .rstn_in    (rstn_in),
    .hold_in    (brg_hold),
    .divisor_in (baud_divisor_r),
    .tick_out   (tick)
  );

  // Bus decode: reads take one wait state so a preceding write is always visible.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_wait_r <= 1'b0;
      rd_idx_r  <= 8'h00;
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 8'h00;
    end else begin
      rd_wait_r <= 1'b0;
      wr_pend_r <= 1'b0;
      if (hsel_in && htrans_in[1] && hready_in) begin
        rd_wait_r <= !hwrite_in;
        wr_pend_r <= hwrite_in;
        rd_idx_r  <= haddr_in[9:2];
        wr_idx_r  <= haddr_in[9:2];
      end
    end
  end

  assign hreadyout_out = !rd_wait_r;
  assign hresp_out     = 1'b0;
  assign wr_status     = wr_pend_r && (wr_idx_r == IDX_RECEIVE_STATUS);
  assign pop           = rd_wait_r && (rd_idx_r == IDX_RECEIVE_FIFO_DATA) &&
                         (count_r != 2'h0);
  assign head          = fifo_r[rd_ptr_r];
  assign receive_complete_flag = (count_r != 2'h0);

  // Read mux; unmapped words and reserved bits read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (rd_idx_r)
      IDX_RECEIVE_STATUS: begin
        rd_mux[POS_SERIAL_PORT_ENABLE]      = ctrl_r.serial_port_enable;
        rd_mux[POS_NINE_BIT_RECEIVE_ENABLE] = ctrl_r.nine_bit_receive_enable;
        rd_mux[POS_SINGLE_RECEIVE_ENABLE]   = ctrl_r.single_receive_enable;
        rd_mux[POS_CONTINUOUS_RECEIVE_EN]   = ctrl_r.continuous_receive_enable;
        rd_mux[POS_OVERRUN_ERROR]           = overrun_error_bit_r;
        rd_mux[POS_RECEIVED_NINTH_BIT]      = receive_complete_flag && head.ninth;
      end
      IDX_TRANSMIT_STATUS: begin
        rd_mux[POS_CLOCK_SOURCE_MASTER] = ctrl_r.clock_source_master;
        rd_mux[POS_TRANSMIT_ENABLE]     = ctrl_r.transmit_enable;
        rd_mux[POS_SYNC_MODE]           = ctrl_r.sync_mode;
      end
      IDX_PERIPHERAL_FLAG:   rd_mux[POS_RECEIVE_COMPLETE] = receive_complete_flag;
      IDX_PERIPHERAL_ENABLE: rd_mux[POS_RECEIVE_COMPLETE] = receive_interrupt_enable_r;
      IDX_BAUD_DIVISOR:      rd_mux[7:0] = baud_divisor_r;
      IDX_RECEIVE_FIFO_DATA: rd_mux[7:0] = receive_complete_flag ? head.data : 8'h00;
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data register is loaded in the wait cycle and held for the data phase.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (rd_wait_r) begin
      hrdata_out <= rd_mux;
    end
  end

  // Control writes; a software write in the same cycle outranks the self-clear.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_r <= '0;
    end else begin
      if (wr_status) begin
        ctrl_r.serial_port_enable        <= hwdata_in[POS_SERIAL_PORT_ENABLE];
        ctrl_r.nine_bit_receive_enable   <= hwdata_in[POS_NINE_BIT_RECEIVE_ENABLE];
        ctrl_r.single_receive_enable     <= hwdata_in[POS_SINGLE_RECEIVE_ENABLE];
        ctrl_r.continuous_receive_enable <= hwdata_in[POS_CONTINUOUS_RECEIVE_EN];
      end else if (last_sample && !ctrl_r.continuous_receive_enable) begin
        ctrl_r.single_receive_enable <= 1'b0;
      end
      // Transmit-side bits are separate, so their write never swallows the self-clear.
      if (wr_pend_r && (wr_idx_r == IDX_TRANSMIT_STATUS)) begin
        ctrl_r.clock_source_master <= hwdata_in[POS_CLOCK_SOURCE_MASTER];
        ctrl_r.transmit_enable     <= hwdata_in[POS_TRANSMIT_ENABLE];
        ctrl_r.sync_mode           <= hwdata_in[POS_SYNC_MODE];
      end
    end
  end

  // Interrupt enable and baud divisor.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      receive_interrupt_enable_r <= 1'b0;
      baud_divisor_r             <= RST_BAUD_DIVISOR;
    end else if (wr_pend_r) begin
      if (wr_idx_r == IDX_PERIPHERAL_ENABLE) begin
        receive_interrupt_enable_r <= hwdata_in[POS_RECEIVE_COMPLETE];
      end
      if (wr_idx_r == IDX_BAUD_DIVISOR) begin
        baud_divisor_r <= hwdata_in[7:0];
      end
    end
  end

  assign rx_irq_out = receive_complete_flag && receive_interrupt_enable_r;

  // Shift clock sequencer: idle low, rises on one tick, falls and samples on the next.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r       <= ST_IDLE;
      clock_level_r <= 1'b0;
      bit_count_r   <= 4'h0;
    end else if (!rx_active) begin
      state_r       <= ST_IDLE;
      clock_level_r <= 1'b0;
      bit_count_r   <= 4'h0;
    end else if (tick) begin
      case (state_r)
        ST_IDLE, ST_LOW: begin
          state_r       <= ST_HIGH;
          clock_level_r <= 1'b1;
        end
        ST_HIGH: begin
          clock_level_r <= 1'b0;
          if (bit_count_r == last_bit) begin
            state_r     <= ST_LOW;
            bit_count_r <= 4'h0;
          end else begin
            state_r     <= ST_IDLE;
            bit_count_r <= bit_count_r + 4'h1;
          end
        end
        default: begin
          state_r       <= ST_IDLE;
          clock_level_r <= 1'b0;
        end
      endcase
    end
  end

  // Sample on the tick that drops the clock, least significant bit first.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      receive_shift_register_r <= 9'h000;
    end else if ((state_r == ST_HIGH) && tick && rx_active) begin
      receive_shift_register_r[bit_count_r] <= serial_data_pin_in;
    end
  end

  // A pop in the same cycle frees a slot, so the word is not counted as overrun.
  assign has_space = (count_r != FIFO_DEPTH) || pop;
  assign push      = last_sample && has_space && !overrun_error_bit_r;

  // Two-entry FIFO of words with their ninth bit.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fifo_r[0] <= '0;
      fifo_r[1] <= '0;
      rd_ptr_r  <= 1'b0;
      count_r   <= 2'h0;
    end else begin
      if (push) begin
        // In eight-bit words bit 7 is still on the pin at the push edge.
        fifo_r[rd_ptr_r ^ count_r[0]].data  <= {ctrl_r.nine_bit_receive_enable ?
          receive_shift_register_r[7] : serial_data_pin_in, receive_shift_register_r[6:0]};
        fifo_r[rd_ptr_r ^ count_r[0]].ninth <=
          ctrl_r.nine_bit_receive_enable && serial_data_pin_in;
      end
      if (pop) begin
        rd_ptr_r <= !rd_ptr_r;
      end
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // Overrun: sticky until the continuous enable is found clear; a word end with no FIFO space wins.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      overrun_error_bit_r <= 1'b0;
    end else if (last_sample && !has_space) begin
      overrun_error_bit_r <= 1'b1;
    end else if (!ctrl_r.continuous_receive_enable) begin
      overrun_error_bit_r <= 1'b0;
    end
  end

  // Pins: receive releases the data pin; the master keeps driving the clock.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      data_pin_r <= 1'b1;
    end else begin
      data_pin_r <= tx_serial_bit_in;
    end
  end

  assign serial_clock_out    = clock_level_r;
  assign serial_clock_oe_out = ctrl_r.serial_port_enable && ctrl_r.sync_mode &&
                               ctrl_r.clock_source_master;
  assign serial_data_pin_out    = data_pin_r;
  assign serial_data_pin_oe_out = ctrl_r.serial_port_enable && ctrl_r.sync_mode &&
                                  ctrl_r.transmit_enable &&
                                  !ctrl_r.single_receive_enable &&
                                  !ctrl_r.continuous_receive_enable;

  // Checks on the receive path.
  sequence s_word_end;
    last_sample;
  endsequence

  sequence s_gap_then_rise;
    (state_r == ST_LOW) ##1 (state_r == ST_LOW || state_r == ST_HIGH);
  endsequence

  a_start_rises: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state_r == ST_IDLE && rx_active && tick) |=> (state_r == ST_HIGH && serial_clock_out))
    else $error("Reception did not raise the shift clock.");

  a_fall_samples: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (state_r == ST_HIGH && tick && rx_active) |=>
      (!serial_clock_out &&
       receive_shift_register_r[$past(bit_count_r)] == $past(serial_data_pin_in)))
    else $error("Data bit not sampled at clock fall.");

  a_single_stops: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (s_word_end and !ctrl_r.continuous_receive_enable and !wr_status) |=>
      !ctrl_r.single_receive_enable ##1 (state_r == ST_IDLE))
    else $error("Single reception did not stop.");

  a_continuous_on: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (s_word_end and ctrl_r.continuous_receive_enable and !wr_status) |=> s_gap_then_rise)
    else $error("Continuous reception did not continue.");

  a_push_on_end: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (last_sample && count_r == 2'h0 && !overrun_error_bit_r) |=>
      (count_r == 2'h1 && receive_complete_flag))
    else $error("Finished word not moved into FIFO.");

  a_irq_gated: assert property (@(posedge clk_in) disable iff (!rstn_in)
    rx_irq_out == (receive_complete_flag && receive_interrupt_enable_r))
    else $error("Interrupt request not gated by enable.");

  a_overrun_sets: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (last_sample && count_r == FIFO_DEPTH && !pop) |=>
      (overrun_error_bit_r && count_r == FIFO_DEPTH))
    else $error("Overrun not flagged on full FIFO.");

  a_overrun_holds: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (overrun_error_bit_r && ctrl_r.continuous_receive_enable) |=> overrun_error_bit_r)
    else $error("Overrun cleared without clearing continuous enable.");

  a_overrun_blocks: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (overrun_error_bit_r && last_sample) |=> (count_r <= $past(count_r)))
    else $error("Transfer into FIFO during overrun.");

  a_brg_held: assert property (@(posedge clk_in) disable iff (!rstn_in)
    brg_hold |-> !tick)
    else $error("Baud generator ran while all enables clear.");

endmodule : sync_master_serial_receiver

`default_nettype wire

/* src/sync_rx_pkg.sv */
// Shared constants and types for the synchronous master receive path.
// Assumes a 32-bit AHB-Lite register bus; register indices are word indices.
`default_nettype none

package sync_rx_pkg;

  // Register word indices; byte address is four times the index.
  localparam logic [7:0] IDX_PERIPHERAL_FLAG    = 8'h0c;
  localparam logic [7:0] IDX_RECEIVE_STATUS     = 8'h18;
  localparam logic [7:0] IDX_RECEIVE_FIFO_DATA  = 8'h1a;
  localparam logic [7:0] IDX_PERIPHERAL_ENABLE  = 8'h8c;
  localparam logic [7:0] IDX_TRANSMIT_STATUS    = 8'h98;
  localparam logic [7:0] IDX_BAUD_DIVISOR       = 8'h99;

  // Bit positions in the receive status/control register.
  localparam int POS_SERIAL_PORT_ENABLE      = 7;
  localparam int POS_NINE_BIT_RECEIVE_ENABLE = 6;
  localparam int POS_SINGLE_RECEIVE_ENABLE   = 5;
  localparam int POS_CONTINUOUS_RECEIVE_EN   = 4;
  localparam int POS_OVERRUN_ERROR           = 1;
  localparam int POS_RECEIVED_NINTH_BIT      = 0;

  // Bit positions in the transmit status/control register.
  localparam int POS_CLOCK_SOURCE_MASTER = 7;
  localparam int POS_TRANSMIT_ENABLE     = 5;
  localparam int POS_SYNC_MODE           = 4;

  // Receive-complete flag and its enable share one position.
  localparam int POS_RECEIVE_COMPLETE = 5;

  // Reset values.
  localparam logic [7:0] RST_BAUD_DIVISOR = 8'h00;

  // Word geometry and FIFO depth.
  localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
  localparam logic [3:0] LAST_BIT_NINE  = 4'h8;
  localparam logic [1:0] FIFO_DEPTH     = 2'h2;

  // One received word with its ninth bit.
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
  } rx_entry_t;

  // Software control bits that steer reception.
  typedef struct packed {
    logic serial_port_enable;
    logic nine_bit_receive_enable;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic clock_source_master;
    logic transmit_enable;
    logic sync_mode;
  } ctrl_t;

  // Shift clock sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HIGH = 3'b010,
    ST_LOW  = 3'b100
  } rx_state_t;

endpackage : sync_rx_pkg

`default_nettype wire

/* tb/serial_slave_model.sv */
// Behavioural external synchronous slave that shifts words out on the master's clock.
// Assumes the bench wires its output onto the data pin whenever the block releases it.
`default_nettype none

module serial_slave_model (
  input  wire logic clk_in,
  input  wire logic sck_in,
  input  wire logic nine_in,
  output logic      dt_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [8:0] words[$];
  logic [8:0] cur;
  int         idx;
  logic       active;

  initial begin
    dt_out = 1'b1;
    cur    = 9'h000;
    idx    = 0;
    active = 1'b0;
  end

  // Queue one word, bit 0 first, ninth bit last.
  task automatic send(input logic [8:0] w);
    words.push_back(w);
  endtask : send

  // Forget any partial word after the master aborted mid-frame.
  task automatic restart();
    idx    = 0;
    active = 1'b0;
  endtask : restart

  // A new bit goes out at each rise, so it is steady by the next fall.
  always @(posedge sck_in) begin
    if (idx == 0) begin
      active = (words.size() != 0);
      if (active) begin
        cur = words.pop_front();
      end
    end
    if (active) begin
      dt_out <= cur[idx];
    end
    idx = (idx == (nine_in ? 8 : 7)) ? 0 : idx + 1;
  end

  // Once a frame is over the line is not trusted to hold its last bit.
  always @(negedge sck_in) begin
    if (idx == 0) begin
      active = 1'b0;
    end
  end

  // Outside frames the line wanders every cycle so stale data cannot pass.
  always @(posedge clk_in) begin
    if (!active) begin
      dt_out <= ~dt_out;
    end
  end
endmodule : serial_slave_model

`default_nettype wire

/* tb/sync_master_serial_receiver_test.sv */
// Self-checking bench for the synchronous master receive path.
// Assumes the block is the only AHB-Lite slave and the slave model drives the data pin.
`default_nettype none

module sync_master_serial_receiver_test;
  import sync_rx_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_in;
  logic        rstn_in;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic        sck;
  logic        sck_oe;
  logic        dt_out;
  logic        dt_oe;
  logic        slave_dt;
  logic        tx_bit;
  logic        nine;
  logic        sck_q;
  int          pulses;
  int          base;
  int          cycles;
  int          errors;
  int          num_checks;
  wire         dt_line = dt_oe ? dt_out : slave_dt;

  sync_master_serial_receiver dut (
    .clk_in                 (clk_in),
    .rstn_in                (rstn_in),
    .hsel_in                (hsel),
    .haddr_in               (haddr),
    .htrans_in              (htrans),
    .hwrite_in              (hwrite),
    .hsize_in               (hsize),
    .hwdata_in              (hwdata),
    .hready_in              (hreadyout),
    .hrdata_out             (hrdata),
    .hreadyout_out          (hreadyout),
    .hresp_out              (hresp),
    .rx_irq_out             (irq),
    .serial_clock_out       (sck),
    .serial_clock_oe_out    (sck_oe),
    .serial_data_pin_in     (dt_line),
    .serial_data_pin_out    (dt_out),
    .serial_data_pin_oe_out (dt_oe),
    .tx_serial_bit_in       (tx_bit)
  );

  serial_slave_model slave (
    .clk_in  (clk_in),
    .sck_in  (sck),
    .nine_in (nine),
    .dt_out  (slave_dt)
  );

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // Clock pulse counter and the hang guard; a long wait means a lost frame.
  always @(posedge clk_in) begin
    sck_q <= sck;
    if (sck && !sck_q) pulses++;
    cycles++;
    if (cycles > 20000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One single AHB-Lite transfer; ready and read data are sampled at rising edges.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_in);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {22'h000000, idx, 2'h0};
    hwrite <= w;
    hsize  <= 3'h2;
    @(posedge clk_in);
    while (hreadyout !== 1'b1) @(posedge clk_in);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_in);
    while (hreadyout !== 1'b1) @(posedge clk_in);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] unused;
    bus(1'b1, idx, {24'h000000, d}, unused);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] v;
    bus(1'b0, idx, 32'h00000000, v);
    chk(v, {24'h000000, exp});
  endtask : rd

  // Let n pulses pass since the caller's base, then let the word settle into the FIFO.
  task automatic wait_pulses(input int n);
    while (pulses < base + n) @(posedge clk_in);
    repeat (10) @(posedge clk_in);
  endtask : wait_pulses

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  initial begin
    {hsel, hwrite, nine} = 3'h0;
    hsize = 3'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    tx_bit = 1'b1;
    rstn_in = 1'b0;
    base = 0;
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    chk({irq, sck_oe, dt_oe}, 3'h0);
    rd(IDX_BAUD_DIVISOR, RST_BAUD_DIVISOR);
    rd(IDX_RECEIVE_STATUS, 8'h00);
    rd(IDX_PERIPHERAL_FLAG, 8'h00);
    wr(8'h01, 8'hff);
    rd(8'h01, 8'h00);
    wr(IDX_BAUD_DIVISOR, 8'h01);
    wr(IDX_TRANSMIT_STATUS, 8'hb0);
    wr(IDX_RECEIVE_STATUS, 8'h80);
    tx_bit <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk({sck_oe, dt_oe, dt_out}, 3'h6);
    $display("test setup done");

    // Single word with the transmitter still enabled.
    slave.send(9'h05a);
    base = pulses;
    wr(IDX_RECEIVE_STATUS, 8'ha0);
    repeat (2) @(posedge clk_in);
    chk(dt_oe, 1'b0);
    wait_pulses(8);
    repeat (40) @(posedge clk_in);
    chk(pulses - base, 8);
    chk(dt_oe, 1'b1);
    rd(IDX_RECEIVE_STATUS, 8'h80);
    rd(IDX_PERIPHERAL_FLAG, 8'h20);
    chk(irq, 1'b0);
    rd(IDX_RECEIVE_FIFO_DATA, 8'h5a);
    rd(IDX_PERIPHERAL_FLAG, 8'h00);
    rd(IDX_RECEIVE_FIFO_DATA, 8'h00);
    tx_bit <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk(dt_out, 1'b1);
    $display("test single done");

    // Nine-bit continuous run that overflows the FIFO on the third word.
    wr(IDX_TRANSMIT_STATUS, 8'h90);
    wr(IDX_PERIPHERAL_ENABLE, 8'h20);
    rd(IDX_PERIPHERAL_ENABLE, 8'h20);
    nine = 1'b1;
    slave.send(9'h1a5);
    slave.send(9'h03c);
    slave.send(9'h1ff);
    base = pulses;
    wr(IDX_RECEIVE_STATUS, 8'hd0);
    wait_pulses(27);
    chk(irq, 1'b1);
    rd(IDX_RECEIVE_STATUS, 8'hd3);
    wr(IDX_RECEIVE_STATUS, 8'hd0);
    rd(IDX_RECEIVE_STATUS, 8'hd3);
    rd(IDX_RECEIVE_FIFO_DATA, 8'ha5);
    rd(IDX_RECEIVE_STATUS, 8'hd2);
    rd(IDX_RECEIVE_FIFO_DATA, 8'h3c);
    chk(irq, 1'b0);
    base = pulses;
    wait_pulses(9);
    rd(IDX_PERIPHERAL_FLAG, 8'h00);
    wr(IDX_RECEIVE_STATUS, 8'hc0);
    rd(IDX_RECEIVE_STATUS, 8'hc0);
    $display("test overrun done");

    // Both enables set: reception carries on past one word.
    nine = 1'b0;
    slave.restart();
    slave.send(9'h011);
    slave.send(9'h022);
    base = pulses;
    wr(IDX_RECEIVE_STATUS, 8'hb0);
    wait_pulses(16);
    rd(IDX_PERIPHERAL_FLAG, 8'h20);
    wr(IDX_RECEIVE_STATUS, 8'h80);
    slave.restart();
    rd(IDX_RECEIVE_FIFO_DATA, 8'h11);
    rd(IDX_RECEIVE_FIFO_DATA, 8'h22);
    $display("test both enables done");
    wrap_up();
  end
endmodule : sync_master_serial_receiver_test

`default_nettype wire
